//--- rtl/hdgc_device.sv
// Card end: decodes the general command and serves the health data block
`timescale 1ns/100ps
`default_nettype none
module hdgc_device
    import hdgc_pkg::*;
(
    input wire logic core_clk, // System clock
    input wire logic rst, // Synchronous reset
    hdgc_link_if.dev link, // Link to host end
    input wire logic [71:0] flash_id, // Flash identity
    input wire logic [15:0] ic_version, // Controller version
    input wire logic [15:0] fw_version, // Firmware version
    input wire logic [7:0] ce_count, // Chip-enable count
    input wire logic [15:0] replace_max, // Maximum replacement blocks
    input wire logic [255:0] bad_per_die, // Bad block count per die
    input wire logic [15:0] good_rate, // Good block rate percent
    input wire logic [31:0] erase_total, // Total erase count
    input wire logic [15:0] remain_life, // Remaining endurance percent
    input wire logic [15:0] erase_avg_lo, // Average erase count low
    input wire logic [15:0] erase_min_lo, // Minimum erase count low
    input wire logic [15:0] erase_max_lo, // Maximum erase count low
    input wire logic [15:0] erase_avg_hi, // Average erase count high
    input wire logic [15:0] erase_min_hi, // Minimum erase count high
    input wire logic [15:0] erase_max_hi, // Maximum erase count high
    input wire logic [31:0] power_up_count, // Power-up count
    input wire logic [15:0] refresh_total, // Total refresh count
    output logic armed, // Health block has been pre-loaded
    output logic [7:0] func_arg1, // Last accepted argument 1
    output logic [7:0] func_arg2, // Last accepted argument 2
    output logic [7:0] func_arg3, // Last accepted argument 3
    output logic preload_done, // Pulse: pre-load block completed
    output logic get_done, // Pulse: health block fully sent
    output logic illegal_seen // Pulse: command rejected
);
    typedef enum logic [1:0] {DV_IDLE, DV_WR, DV_RD} hdgc_dev_state_t;

    hdgc_dev_state_t state;
    logic [8:0] cnt;
    logic [IMAGE_BYTES*8-1:0] image;
    logic [IMAGE_BYTES*8-1:0] next_image;
    logic take;
    logic arg_dir;
    logic [6:0] arg_idx;
    logic is_preload;
    logic is_get;
    logic accept_get;
    logic wr_fire;
    logic rd_fire;

    function automatic logic [7:0] img_byte(input logic [IMAGE_BYTES*8-1:0] img,
                                            input logic [8:0] idx);
        if (idx < 9'(IMAGE_BYTES)) begin
            img_byte = img[idx*8 +: 8];
        end else begin
            img_byte = RSV_BYTE;
        end
    endfunction

    // Field layout of the returned block, multi-byte fields low byte first
    always_comb begin
        next_image = IMAGE_RESET;
        next_image[OFS_FLASH_ID*8 +: 72] = flash_id;
        next_image[OFS_IC_VER*8 +: 16] = ic_version;
        next_image[OFS_FW_VER*8 +: 16] = fw_version;
        next_image[OFS_CE_NUM*8 +: 8] = ce_count;
        next_image[OFS_REPL_MAX*8 +: 16] = replace_max;
        next_image[OFS_BAD_DIE*8 +: 256] = bad_per_die;
        next_image[OFS_GOOD_RATE*8 +: 16] = good_rate;
        next_image[OFS_ERASE_TOTAL*8 +: 32] = erase_total;
        next_image[OFS_REMAIN_LIFE*8 +: 16] = remain_life;
        next_image[OFS_AVG_LO*8 +: 16] = erase_avg_lo;
        next_image[OFS_MIN_LO*8 +: 16] = erase_min_lo;
        next_image[OFS_MAX_LO*8 +: 16] = erase_max_lo;
        next_image[OFS_AVG_HI*8 +: 16] = erase_avg_hi;
        next_image[OFS_MIN_HI*8 +: 16] = erase_min_hi;
        next_image[OFS_MAX_HI*8 +: 16] = erase_max_hi;
        next_image[OFS_POWER_UP*8 +: 32] = power_up_count;
        next_image[OFS_REFRESH*8 +: 16] = refresh_total;
    end

    assign link.cmd_ready = (state == DV_IDLE);
    assign take = link.cmd_valid && link.cmd_ready;
    assign arg_dir = link.cmd_arg[ARG_DIR_BIT];
    assign arg_idx = hdgc_arg_idx(link.cmd_arg);
    assign is_preload = (link.cmd_code == GEN_CMD_CODE) && (arg_dir == DIR_WRITE)
        && (arg_idx == IDX_PRELOAD);
    assign is_get = (link.cmd_code == GEN_CMD_CODE) && (arg_dir == DIR_READ)
        && (arg_idx == IDX_GET);
    // A get before any pre-load has nothing prepared to return
    assign accept_get = is_get && armed;
    assign link.wr_ready = (state == DV_WR);
    assign link.rd_valid = (state == DV_RD);
    assign link.rd_last = (state == DV_RD) && (cnt == LAST_BYTE);
    assign wr_fire = link.wr_valid && link.wr_ready;
    assign rd_fire = link.rd_valid && link.rd_ready;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= DV_IDLE;
        end else begin
            case (state)
                DV_IDLE: begin
                    if (take && is_preload) begin
                        state <= DV_WR;
                    end else if (take && accept_get) begin
                        state <= DV_RD;
                    end
                end
                DV_WR: begin
                    if (wr_fire && cnt == LAST_BYTE) begin
                        state <= DV_IDLE;
                    end
                end
                DV_RD: begin
                    if (rd_fire && cnt == LAST_BYTE) begin
                        state <= DV_IDLE;
                    end
                end
                default: begin
                    state <= DV_IDLE;
                end
            endcase
        end
    end

    // Response follows every taken command by one cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            link.rsp_valid <= 1'b0;
            link.rsp_illegal <= 1'b0;
            illegal_seen <= 1'b0;
        end else begin
            link.rsp_valid <= take;
            link.rsp_illegal <= take && !(is_preload || accept_get);
            illegal_seen <= take && !(is_preload || accept_get);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            func_arg1 <= 8'h00;
            func_arg2 <= 8'h00;
            func_arg3 <= 8'h00;
        end else if (take && (is_preload || accept_get)) begin
            func_arg1 <= link.cmd_arg[ARG_A1_LSB +: 8];
            func_arg2 <= link.cmd_arg[ARG_A2_LSB +: 8];
            func_arg3 <= link.cmd_arg[ARG_A3_LSB +: 8];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt <= 9'h000;
        end else if (take) begin
            cnt <= 9'h000;
        end else if (wr_fire || rd_fire) begin
            cnt <= cnt + 9'h001;
        end
    end

    // Pre-load data is reserved and discarded; the snapshot is taken at block end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            image <= IMAGE_RESET;
            armed <= 1'b0;
            preload_done <= 1'b0;
        end else begin
            preload_done <= 1'b0;
            if (state == DV_WR && wr_fire && cnt == LAST_BYTE) begin
                image <= next_image;
                armed <= 1'b1;
                preload_done <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            link.rd_data <= 8'h00;
            get_done <= 1'b0;
        end else begin
            get_done <= rd_fire && (cnt == LAST_BYTE);
            if (take && accept_get) begin
                link.rd_data <= img_byte(image, 9'h000);
            end else if (rd_fire && cnt != LAST_BYTE) begin
                link.rd_data <= img_byte(image, cnt + 9'h001);
            end
        end
    end
endmodule
`default_nettype wire

//--- shared/hdgc_pkg.sv
// Shared constants and helpers for the health data general command link
`default_nettype none
package hdgc_pkg;
    localparam logic [5:0] GEN_CMD_CODE = 6'h38;
    localparam int ARG_DIR_BIT = 0;
    localparam int ARG_IDX_LSB = 1;
    localparam int ARG_A1_LSB = 8;
    localparam int ARG_A2_LSB = 16;
    localparam int ARG_A3_LSB = 24;
    localparam logic DIR_READ = 1'b1;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic [6:0] IDX_GET = 7'h10;
    localparam logic [6:0] IDX_PRELOAD = 7'h08;
    localparam int BLOCK_BYTES = 512;
    localparam logic [8:0] LAST_BYTE = 9'h1FF;
    localparam logic [7:0] RSV_BYTE = 8'h00;
    localparam int OFS_FLASH_ID = 0;
    localparam int OFS_IC_VER = 9;
    localparam int OFS_FW_VER = 11;
    localparam int OFS_CE_NUM = 14;
    localparam int OFS_REPL_MAX = 16;
    localparam int OFS_BAD_DIE = 32;
    localparam int OFS_GOOD_RATE = 64;
    localparam int OFS_ERASE_TOTAL = 80;
    localparam int OFS_REMAIN_LIFE = 96;
    localparam int OFS_AVG_LO = 98;
    localparam int OFS_MIN_LO = 100;
    localparam int OFS_MAX_LO = 102;
    localparam int OFS_AVG_HI = 104;
    localparam int OFS_MIN_HI = 106;
    localparam int OFS_MAX_HI = 108;
    localparam int OFS_POWER_UP = 112;
    localparam int OFS_REFRESH = 160;
    localparam int IMAGE_BYTES = 216;
    localparam logic [IMAGE_BYTES*8-1:0] IMAGE_RESET = '0;

    function automatic logic [31:0] hdgc_make_arg(input logic dir, input logic [6:0] idx);
        hdgc_make_arg = {24'h000000, idx, dir};
    endfunction

    function automatic logic [6:0] hdgc_arg_idx(input logic [31:0] arg);
        hdgc_arg_idx = arg[ARG_IDX_LSB +: 7];
    endfunction
endpackage
`default_nettype wire

//--- shared/hdgc_link_if.sv
// Link between host controller end and card end of the general command path
`timescale 1ns/100ps
`default_nettype none
interface hdgc_link_if;
    logic cmd_valid;
    logic cmd_ready;
    logic [5:0] cmd_code;
    logic [31:0] cmd_arg;
    logic rsp_valid;
    logic rsp_illegal;
    logic wr_valid;
    logic wr_ready;
    logic [7:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [7:0] rd_data;
    logic rd_last;

    modport dev (
        input cmd_valid, cmd_code, cmd_arg, wr_valid, wr_data, rd_ready,
        output cmd_ready, rsp_valid, rsp_illegal, wr_ready, rd_valid, rd_data, rd_last
    );
    modport host (
        output cmd_valid, cmd_code, cmd_arg, wr_valid, wr_data, rd_ready,
        input cmd_ready, rsp_valid, rsp_illegal, wr_ready, rd_valid, rd_data, rd_last
    );
endinterface
`default_nettype wire

//--- rtl/hdgc_host.sv
// Host end: runs the pre-load then get sequence and delivers the health block
`timescale 1ns/100ps
`default_nettype none
module hdgc_host
    import hdgc_pkg::*;
(
    input wire logic core_clk, // System clock
    input wire logic rst, // Synchronous reset
    hdgc_link_if.host link, // Link to card end
    input wire logic start, // Begin a health data fetch
    output logic busy, // Fetch in progress
    output logic out_valid, // Pulse: out_byte holds one block byte
    output logic [7:0] out_byte, // Block byte
    output logic [8:0] out_index, // Position of out_byte in block
    output logic done, // Pulse: whole block received
    output logic failed // Pulse: card rejected a command
);
    typedef enum logic [2:0] {
        HS_IDLE, HS_PCMD, HS_PRSP, HS_PDAT, HS_GCMD, HS_GRSP, HS_GDAT
    } hdgc_host_state_t;

    hdgc_host_state_t state;
    logic [8:0] cnt;
    logic wr_fire;
    logic rd_fire;

    assign busy = (state != HS_IDLE);
    assign link.cmd_valid = (state == HS_PCMD) || (state == HS_GCMD);
    assign link.cmd_code = GEN_CMD_CODE;
    assign link.wr_valid = (state == HS_PDAT);
    assign link.wr_data = RSV_BYTE;
    assign link.rd_ready = (state == HS_GDAT);
    assign wr_fire = link.wr_valid && link.wr_ready;
    assign rd_fire = link.rd_valid && link.rd_ready;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= HS_IDLE;
            link.cmd_arg <= 32'h00000000;
        end else begin
            case (state)
                HS_IDLE: begin
                    if (start) begin
                        link.cmd_arg <= hdgc_make_arg(DIR_WRITE, IDX_PRELOAD);
                        state <= HS_PCMD;
                    end
                end
                HS_PCMD: begin
                    if (link.cmd_ready) begin
                        state <= HS_PRSP;
                    end
                end
                HS_PRSP: begin
                    if (link.rsp_valid) begin
                        state <= link.rsp_illegal ? HS_IDLE : HS_PDAT;
                    end
                end
                HS_PDAT: begin
                    if (wr_fire && cnt == LAST_BYTE) begin
                        link.cmd_arg <= hdgc_make_arg(DIR_READ, IDX_GET);
                        state <= HS_GCMD;
                    end
                end
                HS_GCMD: begin
                    if (link.cmd_ready) begin
                        state <= HS_GRSP;
                    end
                end
                HS_GRSP: begin
                    if (link.rsp_valid) begin
                        state <= link.rsp_illegal ? HS_IDLE : HS_GDAT;
                    end
                end
                HS_GDAT: begin
                    if (rd_fire && link.rd_last) begin
                        state <= HS_IDLE;
                    end
                end
                default: begin
                    state <= HS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt <= 9'h000;
        end else if (state == HS_PRSP || state == HS_GRSP) begin
            cnt <= 9'h000;
        end else if (wr_fire || rd_fire) begin
            cnt <= cnt + 9'h001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            out_valid <= 1'b0;
            out_byte <= 8'h00;
            out_index <= 9'h000;
            done <= 1'b0;
            failed <= 1'b0;
        end else begin
            out_valid <= rd_fire;
            done <= rd_fire && link.rd_last;
            failed <= (state == HS_PRSP || state == HS_GRSP) && link.rsp_valid
                && link.rsp_illegal;
            if (rd_fire) begin
                out_byte <= link.rd_data;
                out_index <= cnt;
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/hdgc_monitor.sv
// Concurrent checks on the general command link between host and card ends
`timescale 1ns/100ps
`default_nettype none
module hdgc_monitor
    import hdgc_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic rst, // Reset
    input wire logic cmd_valid, // Request
    input wire logic cmd_ready, // Card idle
    input wire logic [5:0] cmd_code, // Code
    input wire logic [31:0] cmd_arg, // Argument
    input wire logic rsp_valid, // Response
    input wire logic rsp_illegal, // Refused
    input wire logic wr_valid, // Write offer
    input wire logic wr_ready, // Write accept
    input wire logic [7:0] wr_data, // Write byte
    input wire logic rd_valid, // Read offer
    input wire logic rd_ready, // Read accept
    input wire logic [7:0] rd_data, // Read byte
    input wire logic rd_last // Final byte
);
    default clocking mon_cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    logic take;
    logic is_pre;
    logic is_get;
    logic primed;
    logic [9:0] wr_cnt;
    logic [9:0] rd_cnt;
    assign take = cmd_valid && cmd_ready;
    assign is_pre = cmd_code == GEN_CMD_CODE && cmd_arg[7:0] == {IDX_PRELOAD, DIR_WRITE};
    assign is_get = cmd_code == GEN_CMD_CODE && cmd_arg[7:0] == {IDX_GET, DIR_READ};
    // Byte handshakes since the command that opened the block
    always_ff @(posedge core_clk) begin
        if (rst || take) begin
            wr_cnt <= 10'h000;
        end else if (wr_valid && wr_ready) begin
            wr_cnt <= wr_cnt + 10'h001;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst || take) begin
            rd_cnt <= 10'h000;
        end else if (rd_valid && rd_ready) begin
            rd_cnt <= rd_cnt + 10'h001;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            primed <= 1'b0;
        end else if (wr_valid && wr_ready && wr_cnt == 10'h1FF) begin
            primed <= 1'b1;
        end
    end
    a_rsp_one_cycle: assert property (take |=> rsp_valid ##1 !rsp_valid)
        else $error("response is not one pulse after the command");
    a_preload_accept: assert property (
        take && is_pre |=> !rsp_illegal && wr_ready && !rd_valid)
        else $error("pre-load not accepted");
    a_get_serves: assert property (take && is_get && primed |=> !rsp_illegal && rd_valid)
        else $error("get not served");
    a_undefined_refused: assert property (take && !is_pre && !is_get |=> rsp_illegal)
        else $error("undefined call not refused");
    a_refusal_clean: assert property (rsp_illegal |-> !rd_valid && !wr_ready ##1 cmd_ready)
        else $error("refused call opened a data phase");
    a_write_length: assert property ($fell(wr_ready) |-> wr_cnt == 10'h200)
        else $error("write block not 512 bytes");
    a_read_last: assert property (rd_valid && rd_last |-> rd_cnt == 10'h1FF)
        else $error("last marker on wrong byte");
    a_read_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
        else $error("read byte changed while stalled");
    a_write_zero: assert property (wr_valid && wr_ready |-> wr_data == RSV_BYTE)
        else $error("pre-load data not zero");
    a_get_reserved: assert property (
        take && cmd_arg[0] |-> cmd_arg[31:8] == 24'h000000 && primed)
        else $error("get sent early or with nonzero argument");
    c_preload: cover property (take && is_pre);
    c_get: cover property (take && is_get);
    c_last: cover property (rd_valid && rd_ready && rd_last);
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Bench: host and card ends back to back, plus a card driven by hand
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import hdgc_pkg::*;
;
    typedef struct packed {
        logic [5:0] code;
        logic [31:0] arg;
        logic ill;
        logic [1:0] kind;
    } hdgc_row_t;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic busy, out_valid, done, failed;
    logic [7:0] out_byte;
    logic [8:0] out_index;
    logic armed_a, armed_b, pre_done_b, get_done_b, ill_b;
    logic [7:0] arg1_b, arg2_b, arg3_b;
    logic [71:0] flash_id = 72'h0102030405060708A9;
    logic [7:0] ce_count = 8'hD4;
    logic [255:0] bad_per_die;
    logic [31:0] erase_total = 32'h70717273, power_up_count = 32'hA0A1A2A3;
    logic [15:0] ic_version = 16'hB1B2, fw_version = 16'hC1C2, replace_max = 16'hE1E2;
    logic [15:0] good_rate = 16'h5A61, remain_life = 16'h6263, refresh_total = 16'hF0F1;
    logic [15:0] erase_avg_lo = 16'h8182, erase_min_lo = 16'h8384, erase_max_lo = 16'h8586;
    logic [15:0] erase_avg_hi = 16'h9192, erase_min_hi = 16'h9394, erase_max_hi = 16'h9596;
    logic [7:0] exp_img [0:511];
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    int got_bytes = 0;
    int k;
    // Kind 0: no data phase, 1: write block, 2: read block
    hdgc_row_t rows [0:8] = '{'{GEN_CMD_CODE, 32'h00000021, 1'b1, 2'h0},
        '{GEN_CMD_CODE, 32'h00000020, 1'b1, 2'h0}, '{GEN_CMD_CODE, 32'h00000011, 1'b1, 2'h0},
        '{GEN_CMD_CODE, 32'h000000FF, 1'b1, 2'h0}, '{GEN_CMD_CODE, 32'h00000000, 1'b1, 2'h0},
        '{6'h37, 32'h00000010, 1'b1, 2'h0}, '{GEN_CMD_CODE, 32'hC3B2A110, 1'b0, 2'h1},
        '{GEN_CMD_CODE, 32'h00000021, 1'b0, 2'h2}, '{GEN_CMD_CODE, 32'h00000021, 1'b0, 2'h2}};
    hdgc_link_if link_a();
    hdgc_link_if link_b();
    hdgc_host hdgc_host_inst (.link(link_a.host), .*);
    hdgc_device hdgc_device_inst (.link(link_a.dev), .armed(armed_a), .func_arg1(), .func_arg2(),
        .func_arg3(), .preload_done(), .get_done(), .illegal_seen(), .*);
    hdgc_device hdgc_device_inst_b (.link(link_b.dev), .armed(armed_b), .func_arg1(arg1_b),
        .func_arg2(arg2_b), .func_arg3(arg3_b), .preload_done(pre_done_b),
        .get_done(get_done_b), .illegal_seen(ill_b), .*);
    hdgc_monitor hdgc_monitor_inst (.core_clk(core_clk), .rst(rst),
        .cmd_valid(link_a.cmd_valid), .cmd_ready(link_a.cmd_ready), .cmd_code(link_a.cmd_code),
        .cmd_arg(link_a.cmd_arg), .rsp_valid(link_a.rsp_valid), .rsp_illegal(link_a.rsp_illegal),
        .wr_valid(link_a.wr_valid), .wr_ready(link_a.wr_ready), .wr_data(link_a.wr_data),
        .rd_valid(link_a.rd_valid), .rd_ready(link_a.rd_ready), .rd_data(link_a.rd_data),
        .rd_last(link_a.rd_last));
    task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
        samples_checked++;
        if (got !== want) begin
            err_total++;
            $display("mismatch at %0t: %s got %0h want %0h", $time, what, got, want);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic put(input int ofs, input logic [255:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            exp_img[ofs + i] = v[8*i +: 8];
        end
    endtask
    // Drives one general command on the hand-driven card and walks its data phase
    task automatic run_row(input hdgc_row_t r);
        int n = 0;
        int w = 0;
        @(negedge core_clk);
        link_b.cmd_valid = 1'b1;
        link_b.cmd_code = r.code;
        link_b.cmd_arg = r.arg;
        while (link_b.cmd_ready !== 1'b1 && w < 2000) begin
            @(negedge core_clk);
            w++;
        end
        @(negedge core_clk);
        link_b.cmd_valid = 1'b0;
        chk(32'(link_b.rsp_valid), 32'h1, "response");
        chk(32'(link_b.rsp_illegal), 32'(r.ill), "refusal flag");
        chk(32'(ill_b), 32'(r.ill), "refusal pulse");
        if (r.kind == 2'h1) begin
            link_b.wr_valid = 1'b1;
            while (n < 512 && w < 4000) begin
                if (link_b.wr_ready === 1'b1) begin
                    n++;
                end
                @(negedge core_clk);
                w++;
            end
            link_b.wr_valid = 1'b0;
            chk(32'(pre_done_b), 32'h1, "pre-load done");
            chk(32'(armed_b), 32'h1, "armed");
        end
        if (r.kind == 2'h2) begin
            while (n < 512 && w < 4000) begin
                link_b.rd_ready = (w % 3) != 0;
                if (link_b.rd_ready) begin
                    chk(32'(link_b.rd_data), 32'(exp_img[n]), "card byte");
                    chk(32'(link_b.rd_last), 32'(n == 511), "last marker");
                    n++;
                end
                @(negedge core_clk);
                w++;
            end
            link_b.rd_ready = 1'b0;
            chk(32'(get_done_b), 32'h1, "get done");
        end
        if (!r.ill) begin
            chk({8'h00, arg3_b, arg2_b, arg1_b}, {8'h00, r.arg[31:8]}, "function args");
        end
    endtask
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 10000) begin
            err_total++;
            $display("mismatch at %0t: timeout", $time);
            stop_test();
        end
    end
    always @(negedge core_clk) begin
        if (!rst && out_valid === 1'b1) begin
            chk(32'(out_byte), 32'(exp_img[out_index]), "host byte");
            got_bytes++;
        end
    end
    initial begin
        link_b.cmd_valid = 1'b0;
        link_b.cmd_code = 6'h00;
        link_b.cmd_arg = 32'h00000000;
        link_b.wr_valid = 1'b0;
        link_b.wr_data = 8'h00;
        link_b.rd_ready = 1'b0;
        for (int i = 0; i < 32; i++) begin
            bad_per_die[8*i +: 8] = 8'(i) + 8'h40;
        end
        for (int i = 0; i < 512; i++) begin
            exp_img[i] = 8'h00;
        end
        put(OFS_FLASH_ID, 256'(flash_id), 9);
        put(OFS_IC_VER, 256'(ic_version), 2);
        put(OFS_FW_VER, 256'(fw_version), 2);
        put(OFS_CE_NUM, 256'(ce_count), 1);
        put(OFS_REPL_MAX, 256'(replace_max), 2);
        put(OFS_BAD_DIE, bad_per_die, 32);
        put(OFS_GOOD_RATE, 256'(good_rate), 2);
        put(OFS_ERASE_TOTAL, 256'(erase_total), 4);
        put(OFS_REMAIN_LIFE, 256'(remain_life), 2);
        put(OFS_AVG_LO, 256'({erase_max_lo, erase_min_lo, erase_avg_lo}), 6);
        put(OFS_AVG_HI, 256'({erase_max_hi, erase_min_hi, erase_avg_hi}), 6);
        put(OFS_POWER_UP, 256'(power_up_count), 4);
        put(OFS_REFRESH, 256'(refresh_total), 2);
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        for (int i = 0; i < 9; i++) begin
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        @(negedge core_clk);
        start = 1'b1;
        @(negedge core_clk);
        chk(32'(busy), 32'h1, "busy during fetch");
        start = 1'b0;
        k = 0;
        while (done !== 1'b1 && failed !== 1'b1 && k < 3000) begin
            @(negedge core_clk);
            k++;
        end
        chk(32'(done), 32'h1, "done pulse");
        @(negedge core_clk);
        chk(32'(failed), 32'h0, "fetch refused");
        chk(32'(got_bytes), 32'h200, "bytes delivered");
        chk(32'(armed_a), 32'h1, "host end armed");
        $display("host fetch done");
        rst = 1'b1;
        @(negedge core_clk);
        rst = 1'b0;
        chk(32'(armed_b), 32'h0, "armed after reset");
        chk(32'(link_b.cmd_ready), 32'h1, "idle after reset");
        chk(32'(busy), 32'h0, "host idle after reset");
        run_row(rows[0]);
        $display("reset test done");
        stop_test();
    end
endmodule
`default_nettype wire
